// ===== common/adc_cfg_consts.svh
// Offsets, field positions, reset values and widths of the config bank
`ifndef ADC_CFG_CONSTS_SVH
`define ADC_CFG_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (command byte carries offset bits 7:1)
// ----------------------------------------------------------------------
`define OFS_CONV_INTERVAL 9'h04E
`define OFS_SETTLING      9'h050
`define OFS_SERIAL_CFG    9'h052

// ----------------------------------------------------------------------
// Serial configuration field positions
// ----------------------------------------------------------------------
`define CFG_IRQ_EN_BIT  3'h7
`define CFG_SEL_POL_BIT 3'h6
`define CFG_CHR_BIT     3'h2
`define CFG_CPHA_BIT    3'h1
`define CFG_CPOL_BIT    3'h0
`define CFG_WRITE_MASK  8'hC7

// ----------------------------------------------------------------------
// Reset values and character framing
// ----------------------------------------------------------------------
`define RST_CONV_INTERVAL 16'h013F
`define RST_SETTLING      16'h002F
`define RST_SERIAL_CFG    8'h80
`define CMD_WRITE_BIT     3'h7
`define LAST_BIT_NARROW   4'h7
`define LAST_BIT_WIDE     4'hF

`endif

// ===== common/adc_cfg_pkg.sv
// Types shared by the ADC timing and serial configuration bank
package adc_cfg_pkg;

  // Position inside one select-framed serial transaction
  typedef enum logic [1:0] {
    FR_CMD,
    FR_DATA_HI,
    FR_DATA_LO,
    FR_DONE
  } frame_e;

  // Complete state of the bank
  typedef struct packed {
    logic        ssel_meta;
    logic        ssel_sync;
    logic        sclk_meta;
    logic        sclk_sync;
    logic        sclk_prev;
    logic        mosi_meta;
    logic        mosi_sync;
    logic [15:0] interval;
    logic [15:0] settling;
    logic [7:0]  cfg;
    frame_e      frame;
    logic [3:0]  bit_cnt;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic        is_write;
    logic [6:0]  addr;
    logic [7:0]  data_hi;
    logic        miso;
    logic        miso_oe;
    logic        char_irq;
    logic [15:0] conv_cnt;
    logic [15:0] settle_cnt;
    logic        conv_start;
  } state_s;

endpackage

// ===== logic/adc_timing_and_spi_config.sv
// ADC conversion pacing and serial-port configuration bank, serial slave
`include "adc_cfg_consts.svh"

module adc_timing_and_spi_config (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // Serial slave pins from the external master
  input  wire logic        i_sclk,
  input  wire logic        i_ssel,
  input  wire logic        i_mosi,
  output logic             o_miso,
  output logic             o_miso_oe,
  // ADC sequencing
  input  wire logic        i_mux_switch,
  output logic             o_conv_start,
  // Mirrors and character interrupt towards the internal processor
  output logic [15:0]      o_conv_interval,
  output logic [15:0]      o_settling_delay,
  output logic [7:0]       o_serial_config,
  output logic             o_char_irq
);

  // ----------------------------------------------------------------------
  // State and decode helpers
  // ----------------------------------------------------------------------
  adc_cfg_pkg::state_s s_r;       // Registered state
  adc_cfg_pkg::state_s s_nxt;     // Next state
  logic                selected;  // Select at its active level
  logic                lead;      // Leading clock edge seen
  logic                trail;     // Trailing clock edge seen
  logic                samp_edge; // Edge that samples MOSI
  logic                shft_edge; // Edge that launches MISO
  logic                char_done; // Last bit of a character sampled
  logic                wr_en;     // Register write commits this cycle
  logic [15:0]         wr_data;   // Word being written
  logic [15:0]         char_word; // Character including the new bit
  logic [15:0]         rd_word;   // Word answered to a read command
  logic [3:0]          last_bit;  // Bit index that ends a character

  // Read data of the addressed register; unmapped reads as zero
  function automatic logic [15:0] read_word(
    input logic [6:0]          addr,
    input adc_cfg_pkg::state_s st
  );
    logic [15:0] w;
    w = 16'h0000;
    if (addr == `OFS_CONV_INTERVAL >> 1) begin
      w = st.interval;
    end else if (addr == `OFS_SETTLING >> 1) begin
      w = st.settling;
    end else if (addr == `OFS_SERIAL_CFG >> 1) begin
      w = {8'h00, st.cfg};
    end
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Everything is computed here; the single register stage follows
  always_comb begin
    s_nxt      = s_r;
    wr_en      = 1'b0;
    wr_data    = 16'h0000;
    char_done  = 1'b0;
    char_word  = {s_r.shift_in[14:0], s_r.mosi_sync};
    rd_word    = read_word(s_r.addr, s_r);
    s_nxt.conv_start = 1'b0;
    s_nxt.char_irq   = 1'b0;

    // Two-stage synchronisers; only the second stage is decoded
    s_nxt.ssel_meta = i_ssel;
    s_nxt.ssel_sync = s_r.ssel_meta;
    s_nxt.sclk_meta = i_sclk;
    s_nxt.sclk_sync = s_r.sclk_meta;
    s_nxt.sclk_prev = s_r.sclk_sync;
    s_nxt.mosi_meta = i_mosi;
    s_nxt.mosi_sync = s_r.mosi_meta;

    // Select is active at the level held in the polarity bit
    selected = (s_r.ssel_sync == s_r.cfg[`CFG_SEL_POL_BIT]);
    // Leading edge leaves the idle level, trailing returns to it
    lead  = (s_r.sclk_sync != s_r.sclk_prev) &&
            (s_r.sclk_sync != s_r.cfg[`CFG_CPOL_BIT]);
    trail = (s_r.sclk_sync != s_r.sclk_prev) &&
            (s_r.sclk_sync == s_r.cfg[`CFG_CPOL_BIT]);
    // Phase bit swaps which edge samples and which launches
    samp_edge = s_r.cfg[`CFG_CPHA_BIT] ? trail : lead;
    shft_edge = s_r.cfg[`CFG_CPHA_BIT] ? lead : trail;
    last_bit  = s_r.cfg[`CFG_CHR_BIT] ? `LAST_BIT_WIDE
                                      : `LAST_BIT_NARROW;

    s_nxt.miso_oe = selected;
    if (!selected) begin
      // Idle select: abandon any partial character or frame
      s_nxt.bit_cnt = 4'h0;
      s_nxt.frame   = adc_cfg_pkg::FR_CMD;
    end else begin
      // Launch the next read bit, MSB first
      if (shft_edge) begin
        s_nxt.miso      = s_r.shift_out[15];
        s_nxt.shift_out = {s_r.shift_out[14:0], 1'b0};
      end
      // Sample MOSI and count bits of the character
      if (samp_edge) begin
        s_nxt.shift_in = char_word;
        if (s_r.bit_cnt == last_bit) begin
          char_done      = 1'b1;
          s_nxt.bit_cnt  = 4'h0;
          s_nxt.char_irq = s_r.cfg[`CFG_IRQ_EN_BIT];
          case (s_r.frame)
            adc_cfg_pkg::FR_CMD: begin
              // Command byte: write flag and word offset
              s_nxt.is_write = char_word[`CMD_WRITE_BIT];
              s_nxt.addr     = char_word[6:0];
              rd_word        = read_word(char_word[6:0], s_r);
              // The next launch edge puts out data bit 15 in either
              // phase. In phase 0 that is the trailing edge of this
              // very pulse, so preloading the pin here would make that
              // edge skip straight on to bit 14.
              s_nxt.shift_out = rd_word;
              s_nxt.frame = s_r.cfg[`CFG_CHR_BIT] ? adc_cfg_pkg::FR_DATA_LO
                                                  : adc_cfg_pkg::FR_DATA_HI;
            end
            adc_cfg_pkg::FR_DATA_HI: begin
              // Narrow characters carry the word high byte first
              s_nxt.data_hi = char_word[7:0];
              s_nxt.frame   = adc_cfg_pkg::FR_DATA_LO;
            end
            adc_cfg_pkg::FR_DATA_LO: begin
              wr_data = s_r.cfg[`CFG_CHR_BIT] ? char_word
                                              : {s_r.data_hi, char_word[7:0]};
              wr_en       = s_r.is_write;
              s_nxt.frame = adc_cfg_pkg::FR_DONE;
            end
            default: begin
              // Extra characters in a frame are counted but ignored
              s_nxt.frame = adc_cfg_pkg::FR_DONE;
            end
          endcase
        end else begin
          s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
        end
      end
    end

    // Register writes land straight in the mirrored controls
    if (wr_en) begin
      if (s_r.addr == `OFS_CONV_INTERVAL >> 1) begin
        s_nxt.interval = wr_data;
      end else if (s_r.addr == `OFS_SETTLING >> 1) begin
        s_nxt.settling = wr_data;
      end else if (s_r.addr == `OFS_SERIAL_CFG >> 1) begin
        // Reserved bits never store, so they always read zero
        s_nxt.cfg = wr_data[7:0] & `CFG_WRITE_MASK;
      end
    end

    // Settling hold: reloaded by every mux switch
    if (i_mux_switch) begin
      s_nxt.settle_cnt = s_r.settling;
    end else if (s_r.settle_cnt != 16'h0000) begin
      s_nxt.settle_cnt = s_r.settle_cnt - 16'h0001;
    end

    // Pacing: one start every interval plus one clocks. The compare is
    // >= so that lowering the interval mid-count cannot strand it.
    if (s_r.conv_cnt >= s_r.interval) begin
      if (s_r.settle_cnt == 16'h0000 && !i_mux_switch) begin
        s_nxt.conv_start = 1'b1;
        s_nxt.conv_cnt   = 16'h0000;
      end
    end else begin
      s_nxt.conv_cnt = s_r.conv_cnt + 16'h0001;
    end

    // Synchronous reset loads the documented defaults
    if (!i_reset_n) begin
      s_nxt            = '0;
      s_nxt.frame      = adc_cfg_pkg::FR_CMD;
      s_nxt.interval   = `RST_CONV_INTERVAL;
      s_nxt.settling   = `RST_SETTLING;
      s_nxt.cfg        = `RST_SERIAL_CFG;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    s_r <= s_nxt;
  end

  // Outputs come straight from state flip-flops
  assign o_miso           = s_r.miso;
  assign o_miso_oe        = s_r.miso_oe;
  assign o_conv_start     = s_r.conv_start;
  assign o_conv_interval  = s_r.interval;
  assign o_settling_delay = s_r.settling;
  assign o_serial_config  = s_r.cfg;
  assign o_char_irq       = s_r.char_irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Helper counters: cycles since the last start and since a mux switch
  logic [16:0] gap_cnt;
  logic [16:0] since_mux;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      gap_cnt   <= 17'h1FFFF;
      since_mux <= 17'h1FFFF;
    end else begin
      gap_cnt   <= o_conv_start ? 17'h00000
                 : (gap_cnt == 17'h1FFFF ? gap_cnt : gap_cnt + 17'h00001);
      since_mux <= i_mux_switch ? 17'h00000
                 : (since_mux == 17'h1FFFF ? since_mux
                                           : since_mux + 17'h00001);
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  chk_conv_spacing: assert property (
    o_conv_start |-> gap_cnt >= {1'b0, o_conv_interval})
    else $error("Conversion starts closer than interval plus one");
  chk_interval_reset: assert property (
    $past(!i_reset_n) |-> o_conv_interval == `RST_CONV_INTERVAL)
    else $error("Interval register not at default after reset");
  chk_settle_hold: assert property (
    o_conv_start |-> since_mux > {1'b0, o_settling_delay})
    else $error("Conversion started inside settling time");
  chk_settle_reset: assert property (
    $past(!i_reset_n) |-> o_settling_delay == `RST_SETTLING)
    else $error("Settling register not at default after reset");
  chk_mirror_write: assert property (
    wr_en && s_r.addr == `OFS_SETTLING >> 1
    |=> o_settling_delay == $past(wr_data))
    else $error("Written settling value not mirrored");
  chk_irq_per_char: assert property (
    char_done |=> o_char_irq == $past(o_serial_config[7]))
    else $error("Character interrupt does not follow enable");
  chk_select_idle: assert property (
    s_r.ssel_sync != o_serial_config[6] |=> s_r.bit_cnt == 4'h0 ##0
    s_r.frame == adc_cfg_pkg::FR_CMD)
    else $error("Frame advanced while select inactive");
  chk_char_length: assert property (
    char_done |-> s_r.bit_cnt == (o_serial_config[2] ? 4'hF : 4'h7))
    else $error("Character length does not match length bit");
  chk_sample_edge: assert property (
    samp_edge |-> $changed(s_r.sclk_sync) ##0
    s_r.sclk_sync == !(o_serial_config[0] ^ o_serial_config[1]))
    else $error("Data sampled on the wrong clock edge");
  chk_reserved_zero: assert property (
    o_serial_config[5:3] == 3'h0)
    else $error("Reserved configuration bits not zero");

  // Output enable follows the decoded select one cycle later, so the
  // data pin is released whenever the master looks elsewhere
  chk_oe_selected: assert property (
    selected |=> o_miso_oe)
    else $error("Data output not enabled while selected");
  chk_oe_idle: assert property (
    !selected |=> !o_miso_oe)
    else $error("Data output enabled while not selected");

  // Every mux switch reloads the settling hold from the register
  chk_settle_load: assert property (
    i_mux_switch |=> s_r.settle_cnt == $past(o_settling_delay))
    else $error("Settling hold not reloaded by mux switch");

  // Serial configuration comes out of reset at its default
  chk_cfg_reset: assert property (
    $past(!i_reset_n) |-> o_serial_config == `RST_SERIAL_CFG)
    else $error("Serial configuration not at default after reset");

  cov_conv_start: cover property (o_conv_start ##[1:400] o_conv_start);
  cov_reg_write:  cover property (wr_en);
  cov_char_irq:   cover property (o_char_irq);
  cov_mux_hold:   cover property (i_mux_switch ##[1:100] o_conv_start);

endmodule

// ===== testbench/spi_master_model.sv
// Behavioural serial master that frames register accesses for the bank
module spi_master_model (
  // Clock used only to align the first edge
  input  wire logic i_clock,
  // Serial pins towards the slave
  output logic      o_sclk,
  output logic      o_ssel,
  output logic      o_mosi,
  input  wire logic i_miso
);
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------------
  // Mode in force at the slave, mirrored here
  // --------------------------------------------------------------------
  logic [7:0] mode_r;  // Copy of the serial configuration

  // Idle: select inactive, clock parked at the default idle level
  initial begin
    mode_r = 8'h80;
    o_sclk = 1'b0;
    o_ssel = 1'b1;
    o_mosi = 1'b0;
  end

  // Follow a new configuration; clock idles at the polarity level
  task automatic set_mode(input logic [7:0] m);
    mode_r = m;
    o_sclk = m[0];
    o_ssel = ~m[6];
  endtask

  // --------------------------------------------------------------------
  // One select-framed transfer: command char, then a 16-bit data word
  // --------------------------------------------------------------------
  task automatic frame(input logic [7:0] cmd, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [31:0] w;
    int          nb;
    nb = mode_r[2] ? 32 : 24;
    w  = mode_r[2] ? {8'h00, cmd, wd} : {cmd, wd, 8'h00};
    rd = 16'h0000;
    @(negedge i_clock);
    o_ssel = mode_r[6];
    #16;
    for (int i = 0; i < nb; i++) begin
      // Phase 0 puts data out before the leading edge
      if (!mode_r[1]) begin
        o_mosi = w[31-i];
      end
      #16;
      // Reading just before the next launch avoids the sync latency
      if (mode_r[1] && i > 0) begin
        rd = {rd[14:0], i_miso};
      end
      o_sclk = ~mode_r[0];
      if (mode_r[1]) begin
        o_mosi = w[31-i];
      end
      #16;
      if (!mode_r[1]) begin
        rd = {rd[14:0], i_miso};
      end
      o_sclk = mode_r[0];
    end
    #16;
    if (mode_r[1]) begin
      rd = {rd[14:0], i_miso};
    end
    // Released data line does not keep its last value
    o_ssel = ~mode_r[6];
    o_mosi = ~o_mosi;
    #16;
  endtask
endmodule

// ===== testbench/adc_timing_and_spi_config_test.sv
// Self-checking bench for the ADC timing and serial config bank
module adc_timing_and_spi_config_test;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic        i_clock = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_mux_switch = 1'b0;
  logic        sclk, ssel, mosi;
  logic        o_miso, o_miso_oe, o_conv_start, o_char_irq;
  logic [15:0] o_conv_interval, o_settling_delay, rd;
  logic [7:0]  o_serial_config;
  int          errors = 0;
  int          n_tests = 0;
  int          irq_cnt = 0;
  int          n;

  // 250 MHz clock
  always #2 i_clock = ~i_clock;

  // Counts interrupt pulses towards the processor
  always @(posedge i_clock) begin
    if (o_char_irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
  end

  adc_timing_and_spi_config uut (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_sclk(sclk),
    .i_ssel(ssel), .i_mosi(mosi), .o_miso(o_miso),
    .o_miso_oe(o_miso_oe), .i_mux_switch(i_mux_switch),
    .o_conv_start(o_conv_start), .o_conv_interval(o_conv_interval),
    .o_settling_delay(o_settling_delay),
    .o_serial_config(o_serial_config), .o_char_irq(o_char_irq));

  spi_master_model master (
    .i_clock(i_clock), .o_sclk(sclk), .o_ssel(ssel), .o_mosi(mosi),
    .i_miso(o_miso));

  // --------------------------------------------------------------------
  // Compare and report
  // --------------------------------------------------------------------
  task automatic check_val(string nm, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic check_cnt(string nm, int exp, int got);
    n_tests++;
    if (got != exp) begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cycles until the next conversion start, bounded
  task automatic wait_start(output int cyc);
    cyc = 0;
    do begin
      @(negedge i_clock);
      i_mux_switch = 1'b0;
      cyc++;
      if (cyc > 400) begin
        errors++;
        $display("mismatch conv_start wait expected pulse seen none");
        print_verdict();
      end
    end while (o_conv_start !== 1'b1);
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    check_val("interval", 16'h013F, o_conv_interval);
    check_val("settling", 16'h002F, o_settling_delay);
    check_val("config", 16'h0080, {8'h00, o_serial_config});
    check_val("miso enable idle", 16'h0000, {15'h0000, o_miso_oe});
    master.frame(8'h27, 16'h0000, rd);
    check_val("interval read", 16'h013F, rd);
    // Settling is only read here, never rewritten
    master.frame(8'h28, 16'h0000, rd);
    check_val("settling read", 16'h002F, rd);
    master.frame(8'h10, 16'h0000, rd);
    check_val("unmapped read", 16'h0000, rd);
  endtask

  task automatic t_pacing();
    wait_start(n);
    wait_start(n);
    check_cnt("default spacing", 320, n);
    master.frame(8'hA7, 16'h0009, rd);
    check_val("interval mirror", 16'h0009, o_conv_interval);
    wait_start(n);
    wait_start(n);
    check_cnt("short spacing", 10, n);
  endtask

  // A start is pending during the wait, so it fires right at the end
  task automatic t_settle();
    wait_start(n);
    i_mux_switch = 1'b1;
    wait_start(n);
    check_cnt("settling hold", 49, n);
  endtask

  // Every field value twice; reads framed in the mode just written
  task automatic t_config();
    logic [7:0] wr [4] = '{8'hFF, 8'h06, 8'h41, 8'h80};
    logic [7:0] ex [4] = '{8'hC7, 8'h06, 8'h41, 8'h80};
    int         base;
    for (int k = 0; k < 4; k++) begin
      master.frame(8'hA9, {8'h00, wr[k]}, rd);
      check_val("config mirror", {8'h00, ex[k]},
                {8'h00, o_serial_config});
      master.set_mode(ex[k]);
      repeat (4) @(negedge i_clock);
      base = irq_cnt;
      master.frame(8'h29, 16'h0000, rd);
      repeat (6) @(negedge i_clock);
      check_val("config read", {8'h00, ex[k]}, rd);
      check_cnt("char irqs", ex[k][7] ? (ex[k][2] ? 2 : 3) : 0,
                irq_cnt - base);
    end
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (10) @(negedge i_clock);
    i_reset_n = 1'b1;
    repeat (6) @(negedge i_clock);
    t_reset();
    t_pacing();
    t_settle();
    t_config();
    print_verdict();
  end
endmodule
